// File: include/swpl_pkg.sv
// shared constants and carrier types for the serial wiper position loader
package swpl_pkg;
	localparam int          WIPER_BITS    = 7;
	localparam int          TAP_COUNT     = 128;
	localparam logic [6:0]  MIDSCALE_CODE = 7'h40;
	localparam logic [6:0]  ZERO_CODE     = 7'h00;
	localparam logic [6:0]  SHIFT_CLEAR   = 7'h00;
	localparam int          SHIFT_MSB     = 6;

	// raw pin levels arriving from the host side
	typedef struct packed {
		logic chip_select_n;
		logic serial_clk;
		logic serial_in;
		logic midscale_reset_n;
		logic sleep_n;
	} swpl_pins_t;

	// resistor switch controls leaving the block
	typedef struct packed {
		logic [127:0] tap_select;
		logic         a_end_switch;
		logic         b_end_switch;
	} swpl_switch_t;
endpackage

// File: core/swpl_sync.sv
// two-flop synchroniser for the asynchronous control pins
module swpl_sync #(
	parameter int WIDTH = 5
) (
	input  wire logic             clk_sys,
	input  wire logic             reset_n,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage1_reg;

	// the first stage feeds only the second stage
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			stage1_reg <= '0;
			sync_out   <= '0;
		end else begin
			stage1_reg <= async_in;
			sync_out   <= stage1_reg;
		end
	end
endmodule

// File: core/swpl_core.sv
// serial wiper position loader: shift register, wiper latch, tap decoder

// Behaviour
// - chip select is active low; serial activity counts only while it is low.
// - chip select rising copies the shifted word into the wiper latch.
// - data sampled on serial clock rising edges only; falling edges ignored.
// - midscale reset forces the wiper latch to midscale.
// - sleep opens the A end and ties wiper to B regardless of code.
// - writes are still accepted during sleep, giving a programmable preset.
// - seven-bit latch decoded to one of 128 taps.
// - code is unsigned, zero through 127, each a distinct tap.
// - code zero closes the B end switch directly.
// - code one selects first tap above B, counting upward.
// - larger code moves the wiper toward A, monotonically.
// - midscale code is 0x40, also latched on reset release with select high.
// - each rising serial clock in a frame shifts one bit in.
// - serial output presents previous frame bits delayed by seven clocks.
// - more than seven bits per frame keeps only the last seven.
module swpl_core (
	input  wire logic               clk_sys,
	input  wire logic               reset_n,
	input  wire swpl_pkg::swpl_pins_t pins,
	output logic                    serial_out_o,
	output logic                    serial_out_oe,
	output logic [6:0]              wiper_code,
	output swpl_pkg::swpl_switch_t  switches
);
	import swpl_pkg::*;

	// idle pin levels; a synchroniser that reset to zero would show select low and
	// then a false select rise, loading the cleared shift register after reset
	localparam swpl_pins_t PIN_IDLE = '{
		chip_select_n:    1'b1,
		serial_clk:       1'b0,
		serial_in:        1'b0,
		midscale_reset_n: 1'b1,
		sleep_n:          1'b1
	};

	swpl_pins_t pins_flip;
	swpl_pins_t flip_sync;
	swpl_pins_t pins_s;
	logic       cs_n_s;
	logic       sclk_s;
	logic       sdi_s;
	logic       mrst_n_s;
	logic       sleep_n_s;
	logic       sclk_prev_reg;
	logic       cs_n_prev_reg;
	logic       sclk_rise;
	logic       cs_rise;
	logic [6:0] shift_reg;
	logic [6:0] wiper_latch;
	logic       out_bit_reg;

	// one-hot decode: code n closes tap n, tap 0 being the B end switch
	function automatic logic [127:0] swpl_decode(input logic [6:0] code);
		logic [127:0] onehot;
		onehot       = '0;
		onehot[code] = 1'b1;
		return onehot;
	endfunction

	// pins are flipped so that the synchroniser's zero reset stands for idle
	assign pins_flip = pins ^ PIN_IDLE;

	// every pin crosses two flops before any logic looks at it
	swpl_sync #(
		.WIDTH($bits(swpl_pins_t))
	) u_sync (
		.clk_sys (clk_sys),
		.reset_n (reset_n),
		.async_in(pins_flip),
		.sync_out(flip_sync)
	);

	assign pins_s    = flip_sync ^ PIN_IDLE;
	assign cs_n_s    = pins_s.chip_select_n;
	assign sclk_s    = pins_s.serial_clk;
	assign sdi_s     = pins_s.serial_in;
	assign mrst_n_s  = pins_s.midscale_reset_n;
	assign sleep_n_s = pins_s.sleep_n;

	// edge history; idle state assumes select high and clock low
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			sclk_prev_reg <= 1'b0;
			cs_n_prev_reg <= 1'b1;
		end else begin
			sclk_prev_reg <= sclk_s;
			cs_n_prev_reg <= cs_n_s;
		end
	end

	assign sclk_rise = sclk_s & ~sclk_prev_reg;
	assign cs_rise   = cs_n_s & ~cs_n_prev_reg;

	// shift register; sleep does not block shifting so presets can load
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			shift_reg <= SHIFT_CLEAR;
		end else if (!mrst_n_s) begin
			shift_reg <= SHIFT_CLEAR;
		end else if (sclk_rise && !cs_n_s) begin
			shift_reg <= {shift_reg[SHIFT_MSB-1:0], sdi_s};
		end
	end

	// serial output stage: bit leaving the top of the register, seven clocks late
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			out_bit_reg <= 1'b0;
		end else if (!mrst_n_s) begin
			out_bit_reg <= 1'b0;
		end else if (sclk_rise && !cs_n_s) begin
			out_bit_reg <= shift_reg[SHIFT_MSB];
		end
	end

	// open drain: pull low only while a frame is active and not asleep
	assign serial_out_o  = 1'b0;
	assign serial_out_oe = !cs_n_s && sleep_n_s && !out_bit_reg;

	// wiper latch: reset has priority over a pending load
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			wiper_latch <= MIDSCALE_CODE;
		end else if (!mrst_n_s) begin
			wiper_latch <= MIDSCALE_CODE;
		end else if (cs_rise) begin
			wiper_latch <= shift_reg;
		end
	end

	assign wiper_code = wiper_latch;

	// switch outputs; sleep overrides the decode but never alters the latch
	always_comb begin
		switches.tap_select = swpl_decode(wiper_latch);
		switches.a_end_switch = 1'b1;
		switches.b_end_switch = (wiper_latch == ZERO_CODE);
		if (!sleep_n_s) begin
			switches.tap_select   = swpl_decode(ZERO_CODE);
			switches.a_end_switch = 1'b0;
			switches.b_end_switch = 1'b1;
		end
	end
endmodule

// File: verification/swpl_assertions.sv
// checker for decode, load and sleep relations
module swpl_chk (
	input wire logic                   clk_sys,
	input wire logic                   reset_n,
	input wire swpl_pkg::swpl_pins_t   pins,
	input wire logic                   serial_out_o,
	input wire logic                   serial_out_oe,
	input wire logic [6:0]             wiper_code,
	input wire swpl_pkg::swpl_switch_t switches
);
	timeunit 1ns;
	timeprecision 1ns;
	import swpl_pkg::*;
	// pins pass a synchroniser, so pin causes are held a few edges first
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	tap_onehot_a: assert property ($onehot(switches.tap_select))
		else $error("tap not one-hot");
	tap_index_a: assert property (
		switches.a_end_switch |-> switches.tap_select[wiper_code]) else $error("tap off code");
	b_end_a: assert property (switches.b_end_switch ==
		(wiper_code == ZERO_CODE || !switches.a_end_switch)) else $error("b end wrong");
	sleep_tap_a: assert property (
		!switches.a_end_switch |-> switches.tap_select[0]) else $error("sleep tap");
	mid_set_a: assert property (
		!pins.midscale_reset_n [*3] |=> wiper_code == MIDSCALE_CODE) else $error("no midscale");
	// eight idle edges clear the load latency, also after reset
	code_hold_a: assert property (
		(pins.chip_select_n && pins.midscale_reset_n) [*8] |=> $stable(wiper_code))
		else $error("code moved");
	oe_idle_a: assert property (
		pins.chip_select_n [*4] |-> !serial_out_oe) else $error("out driven");
	sleep_open_a: assert property (
		!pins.sleep_n [*4] |-> !switches.a_end_switch && !serial_out_oe) else $error("a end");
	cover property (wiper_code == ZERO_CODE);
	cover property ($rose(pins.chip_select_n));
	cover property (!switches.a_end_switch ##1 switches.a_end_switch);
endmodule

// File: verification/swpl_host.sv
// host model driving the three-wire bus and control pins
module swpl_host (
	input  wire logic           clk_sys,
	output swpl_pkg::swpl_pins_t pins
);
	timeunit 1ns;
	timeprecision 1ns;
	import swpl_pkg::*;
	initial pins = 5'h13; // select, midscale and sleep high, clock low
	task automatic step(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	// clock idles low between frames; data flips so no stale level lingers
	task automatic send(input logic [15:0] word, input int nbits);
		pins.chip_select_n = 1'b0;
		for (int i = nbits - 1; i >= 0; i--) begin
			pins.serial_in = word[i];
			step(4);
			pins.serial_clk = 1'b1;
			step(4);
			pins.serial_clk = 1'b0;
		end
		step(4);
		pins.chip_select_n = 1'b1;
		pins.serial_in = ~pins.serial_in;
		step(4);
	endtask
endmodule

// File: verification/test_serial_wiper_position_loader.sv
// bench: frames, sleep preset and midscale against a model code
module test_serial_wiper_position_loader;
	timeunit 1ns;
	timeprecision 1ns;
	import swpl_pkg::*;
	logic         clk_sys = 1'b0;
	logic         reset_n = 1'b0;
	swpl_pins_t   pins;
	swpl_switch_t sw;
	logic [6:0]   code;
	logic         serial_out;
	logic         sdo_oe;
	logic [15:0]  w;
	int           sh_q[$];
	int           out_bit = 0;
	int           errors = 0;
	int           cmp_count = 0;
	always #50 clk_sys = ~clk_sys;
	swpl_host host (.clk_sys(clk_sys), .pins(pins));
	swpl_core dut (.clk_sys(clk_sys), .reset_n(reset_n), .pins(pins), .serial_out_o(serial_out),
		.serial_out_oe(sdo_oe), .wiper_code(code), .switches(sw));
	task automatic check(input string name, input logic [127:0] seen, input logic [127:0] want);
		cmp_count++;
		if (seen !== want) begin
			errors++;
			$display("Error %s expected %h seen %h", name, want, seen);
		end
	endtask
	// shift path model: at each presented rise the open drain shows the bit eight rises back
	always @(posedge pins.serial_clk) begin
		if (!pins.midscale_reset_n) begin
			sh_q.delete();
			repeat (7) sh_q.push_back(0);
			out_bit = 0;
		end
		check("serial_out_o", 128'(serial_out), 128'h0);
		check("serial_out_oe", 128'(sdo_oe), 128'(pins.sleep_n && out_bit == 0));
		if (pins.midscale_reset_n) begin
			out_bit = sh_q.pop_front();
			sh_q.push_back(int'(pins.serial_in));
		end
	end
	task automatic end_sim;
		$display("errors %0d compares %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// 7, 11 and 15 bit frames; one loaded while asleep
	initial begin
		void'($urandom(56840));
		repeat (7) sh_q.push_back(0);
		repeat (3) @(posedge clk_sys);
		#1 reset_n = 1'b1;
		host.step(4);
		check("wiper_code", 128'(code), 128'(MIDSCALE_CODE));
		for (int k = 0; k < 9; k++) begin
			w = (k == 0) ? 16'h0 : (k == 1) ? 16'h7f : 16'($urandom);
			if (k == 4)
				host.pins.sleep_n = 1'b0;
			host.send(w, 7 + k % 3 * 4);
			check("wiper_code", 128'(code), 128'(w[6:0]));
			check("a_end_switch", 128'(sw.a_end_switch), 128'(k != 4));
			check("b_end_switch", 128'(sw.b_end_switch),
				128'(k == 4 || w[6:0] == ZERO_CODE));
			check("tap_select", sw.tap_select,
				(k == 4) ? 128'h1 : 128'h1 << w[6:0]);
			host.pins.sleep_n = 1'b1;
			host.step(4);
			check("tap_select", sw.tap_select, 128'h1 << w[6:0]);
		end
		host.pins.midscale_reset_n = 1'b0;
		host.send(16'h15, 7);
		check("wiper_code", 128'(code), 128'(MIDSCALE_CODE));
		host.pins.midscale_reset_n = 1'b1;
		host.step(4);
		check("wiper_code", 128'(code), 128'(MIDSCALE_CODE));
		end_sim();
	end
	initial begin
		#2000000;
		errors++;
		end_sim();
	end
endmodule
bind swpl_core swpl_chk chk (.clk_sys(clk_sys), .reset_n(reset_n), .pins(pins),
	.serial_out_o(serial_out_o), .serial_out_oe(serial_out_oe),
	.wiper_code(wiper_code), .switches(switches));
